/* rtl/asrx_pkg.sv */
// Constants, register map and field layout of the serial receiver block
package asrx_pkg;
  localparam logic [7:0] ASRX_CTRL_OFF = 8'h00;
  localparam logic [7:0] ASRX_STAT_OFF = 8'h04;
  localparam logic [7:0] ASRX_DATA_OFF = 8'h08;
  localparam logic [7:0] ASRX_IFLAG_OFF = 8'h0c;
  localparam logic [7:0] ASRX_IMASK_OFF = 8'h10;
  // Control fields
  localparam int ASRX_CTRL_TRANSMIT_ENABLE_BIT_BIT = 0;
  localparam int ASRX_CTRL_TRANSMIT_TRIGGER_BIT = 1;
  localparam int ASRX_CTRL_RECEIVE_ENABLE_BIT_BIT = 2;
  localparam int ASRX_CTRL_RXACK_BIT = 3;
  localparam int ASRX_CTRL_PSENSE_BIT = 4;
  localparam int ASRX_CTRL_PEN_BIT = 5;
  localparam int ASRX_CTRL_MODE8_BIT = 6;
  // Error status fields
  localparam int ASRX_STAT_OER_BIT = 0;
  localparam int ASRX_STAT_PER_BIT = 1;
  localparam int ASRX_STAT_FER_BIT = 2;
  // Interrupt flag and mask fields
  localparam int ASRX_IRQ_RC_BIT = 0;
  localparam int ASRX_IRQ_TC_BIT = 1;
  localparam int ASRX_IRQ_ER_BIT = 2;
  localparam logic [6:0] ASRX_CTRL_RESET = 7'h40;
  localparam logic [15:0] ASRX_BAUD_DIV_RESET = 16'd16;
  localparam logic [1:0] ASRX_RESP_OKAY = 2'b00;
  localparam logic [1:0] ASRX_RESP_SLVERR = 2'b10;
endpackage

/* rtl/asrx_uart.sv */
// Asynchronous serial receiver with error flags, plus transmitter and serial interrupts
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module asrx_uart #(
  parameter int DIV_W = 16
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [DIV_W-1:0] shift_clk_div_in,
  input wire logic serial_input_line_in,
  output logic serial_output_line_out,
  input wire logic cpu_irq_enable_in,
  output logic error_irq_out,
  output logic rx_complete_irq_out,
  output logic tx_complete_irq_out
);

  // ****************************************
  // Bus write side
  // ****************************************
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  wire aw_take = s_axi_awvalid_in && !aw_hold_reg && !bvalid_reg;
  wire w_take = s_axi_wvalid_in && !w_hold_reg && !bvalid_reg;
  wire wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire wr_lane0 = wr_go && w_strb_reg[0];
  wire wr_ctrl = wr_lane0 && (aw_addr_reg == asrx_pkg::ASRX_CTRL_OFF);
  wire wr_stat = wr_lane0 && (aw_addr_reg == asrx_pkg::ASRX_STAT_OFF);
  wire wr_data = wr_lane0 && (aw_addr_reg == asrx_pkg::ASRX_DATA_OFF);
  wire wr_iflag = wr_lane0 && (aw_addr_reg == asrx_pkg::ASRX_IFLAG_OFF);
  wire wr_imask = wr_lane0 && (aw_addr_reg == asrx_pkg::ASRX_IMASK_OFF);
  wire wr_mapped = (aw_addr_reg == asrx_pkg::ASRX_CTRL_OFF) ||
                   (aw_addr_reg == asrx_pkg::ASRX_STAT_OFF) ||
                   (aw_addr_reg == asrx_pkg::ASRX_DATA_OFF) ||
                   (aw_addr_reg == asrx_pkg::ASRX_IFLAG_OFF) ||
                   (aw_addr_reg == asrx_pkg::ASRX_IMASK_OFF);
  wire [7:0] wb = w_data_reg[7:0];

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= asrx_pkg::ASRX_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_in;
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in;
        w_strb_reg <= s_axi_wstrb_in;
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? asrx_pkg::ASRX_RESP_OKAY : asrx_pkg::ASRX_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready_in) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic transmit_enable_bit_reg;
  logic receive_enable_bit_reg;
  logic psense_reg;
  logic pen_reg;
  logic mode8_reg;
  logic [7:0] tx_data_reg;
  logic [2:0] imask_reg;
  logic acked_reg;
  wire rx_ack_wr = wr_ctrl && wb[asrx_pkg::ASRX_CTRL_RXACK_BIT];
  wire receive_enable_bit_clr_wr = wr_ctrl && !wb[asrx_pkg::ASRX_CTRL_RECEIVE_ENABLE_BIT_BIT];
  wire tx_trig_wr = wr_ctrl && wb[asrx_pkg::ASRX_CTRL_TRANSMIT_TRIGGER_BIT];

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      transmit_enable_bit_reg <= asrx_pkg::ASRX_CTRL_RESET[asrx_pkg::ASRX_CTRL_TRANSMIT_ENABLE_BIT_BIT];
      receive_enable_bit_reg <= asrx_pkg::ASRX_CTRL_RESET[asrx_pkg::ASRX_CTRL_RECEIVE_ENABLE_BIT_BIT];
      psense_reg <= asrx_pkg::ASRX_CTRL_RESET[asrx_pkg::ASRX_CTRL_PSENSE_BIT];
      pen_reg <= asrx_pkg::ASRX_CTRL_RESET[asrx_pkg::ASRX_CTRL_PEN_BIT];
      mode8_reg <= asrx_pkg::ASRX_CTRL_RESET[asrx_pkg::ASRX_CTRL_MODE8_BIT];
      tx_data_reg <= 8'h00;
      imask_reg <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        transmit_enable_bit_reg <= wb[asrx_pkg::ASRX_CTRL_TRANSMIT_ENABLE_BIT_BIT];
        receive_enable_bit_reg <= wb[asrx_pkg::ASRX_CTRL_RECEIVE_ENABLE_BIT_BIT];
        psense_reg <= wb[asrx_pkg::ASRX_CTRL_PSENSE_BIT];
        pen_reg <= wb[asrx_pkg::ASRX_CTRL_PEN_BIT];
        mode8_reg <= wb[asrx_pkg::ASRX_CTRL_MODE8_BIT];
      end
      if (wr_data) begin
        tx_data_reg <= wb;
      end
      if (wr_imask) begin
        imask_reg <= wb[2:0];
      end
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  typedef enum logic [1:0] {ASRX_IDLE, ASRX_START, ASRX_BITS, ASRX_STOP} asrx_rx_state_t;
  asrx_rx_state_t rx_state_reg;
  logic [DIV_W-1:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  logic [8:0] rx_shift_reg;
  logic [7:0] rx_buf_reg;
  logic oer_reg;
  logic per_reg;
  logic fer_reg;
  logic rc_flag_reg;
  logic tc_flag_reg;
  logic er_flag_reg;
  wire [DIV_W-1:0] half_div = shift_clk_div_in >> 1;
  wire rx_tick = (rx_cnt_reg == '0);
  wire [3:0] data_bits = mode8_reg ? 4'd8 : 4'd7;
  wire [3:0] frame_bits = data_bits + {3'b000, pen_reg};
  // Received bits right-aligned in the shift register
  wire [8:0] rx_aligned = rx_shift_reg >> (4'd9 - frame_bits);
  wire [7:0] rx_data_only = mode8_reg ? rx_aligned[7:0] : {1'b0, rx_aligned[6:0]};
  wire rx_par_bit = rx_aligned[data_bits];
  wire rx_ones_odd = ^rx_data_only ^ rx_par_bit;
  wire rx_done = (rx_state_reg == ASRX_STOP) && rx_tick && receive_enable_bit_reg;
  wire stop_bad = !serial_input_line_in;
  wire par_bad = pen_reg && (rx_ones_odd != psense_reg);
  wire overrun = !acked_reg || rx_ack_wr;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_state_reg <= ASRX_IDLE;
      rx_cnt_reg <= '0;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
      rx_buf_reg <= 8'h00;
      acked_reg <= 1'b1;
    end else begin
      rx_cnt_reg <= rx_tick ? shift_clk_div_in : rx_cnt_reg - 1'b1;
      if (!receive_enable_bit_reg) begin
        rx_state_reg <= ASRX_IDLE;
      end else begin
        unique case (rx_state_reg)
          ASRX_IDLE: begin
            if (!serial_input_line_in) begin
              rx_state_reg <= ASRX_START;
              rx_cnt_reg <= half_div;
            end
          end
          ASRX_START: begin
            if (rx_tick) begin
              rx_state_reg <= serial_input_line_in ? ASRX_IDLE : ASRX_BITS;
              rx_bit_reg <= 4'h0;
            end
          end
          ASRX_BITS: begin
            if (rx_tick) begin
              rx_shift_reg <= {serial_input_line_in, rx_shift_reg[8:1]};
              rx_bit_reg <= rx_bit_reg + 4'h1;
              if (rx_bit_reg + 4'h1 == frame_bits) begin
                rx_state_reg <= ASRX_STOP;
              end
            end
          end
          ASRX_STOP: begin
            if (rx_tick) begin
              rx_state_reg <= ASRX_IDLE;
              rx_buf_reg <= rx_data_only;
            end
          end
        endcase
      end
      if (rx_done) begin
        acked_reg <= 1'b0;
      end else if (rx_ack_wr) begin
        acked_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // Transmitter
  // ****************************************
  logic [DIV_W-1:0] tx_cnt_reg;
  logic [3:0] tx_left_reg;
  logic [10:0] tx_shift_reg;
  logic tx_busy_reg;
  logic sout_reg;
  wire tx_tick = (tx_cnt_reg == '0);
  wire [7:0] tx_data = mode8_reg ? tx_data_reg : {1'b0, tx_data_reg[6:0]};
  wire tx_par = ^tx_data ^ psense_reg;
  wire [10:0] tx_frame = !pen_reg ? {2'b11, tx_data[7] | !mode8_reg, tx_data[6:0], 1'b0} :
                         mode8_reg ? {1'b1, tx_par, tx_data, 1'b0} :
                         {2'b11, tx_par, tx_data[6:0], 1'b0};
  wire tx_finish = tx_busy_reg && tx_tick && (tx_left_reg == 4'h1);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_cnt_reg <= '0;
      tx_left_reg <= 4'h0;
      tx_shift_reg <= 11'h7ff;
      tx_busy_reg <= 1'b0;
      sout_reg <= 1'b1;
    end else begin
      tx_cnt_reg <= tx_tick ? shift_clk_div_in : tx_cnt_reg - 1'b1;
      if (!transmit_enable_bit_reg) begin
        tx_busy_reg <= 1'b0;
        sout_reg <= 1'b1;
      end else if (!tx_busy_reg && tx_trig_wr) begin
        tx_busy_reg <= 1'b1;
        tx_shift_reg <= tx_frame;
        tx_left_reg <= frame_bits + 4'd2;
        tx_cnt_reg <= '0;
      end else if (tx_busy_reg && tx_tick) begin
        sout_reg <= tx_shift_reg[0];
        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
        tx_left_reg <= tx_left_reg - 4'h1;
        if (tx_left_reg == 4'h1) begin
          tx_busy_reg <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Error and interrupt flags
  // ****************************************
  wire clr_oer = wr_stat && wb[asrx_pkg::ASRX_STAT_OER_BIT];
  wire clr_per = wr_stat && wb[asrx_pkg::ASRX_STAT_PER_BIT];
  wire clr_fer = wr_stat && wb[asrx_pkg::ASRX_STAT_FER_BIT];
  wire set_oer = rx_done && overrun;
  wire set_per = rx_done && par_bad;
  wire set_fer = rx_done && stop_bad;
  wire set_rc = rx_done && !overrun;
  wire set_er = set_oer || set_per || set_fer;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      oer_reg <= 1'b0;
      per_reg <= 1'b0;
      fer_reg <= 1'b0;
      rc_flag_reg <= 1'b0;
      tc_flag_reg <= 1'b0;
      er_flag_reg <= 1'b0;
    end else begin
      oer_reg <= set_oer || (oer_reg && !clr_oer && !receive_enable_bit_clr_wr);
      per_reg <= set_per || (per_reg && !clr_per && !receive_enable_bit_clr_wr);
      fer_reg <= set_fer || (fer_reg && !clr_fer && !receive_enable_bit_clr_wr);
      rc_flag_reg <= set_rc ||
        (rc_flag_reg && !(wr_iflag && wb[asrx_pkg::ASRX_IRQ_RC_BIT]));
      tc_flag_reg <= tx_finish ||
        (tc_flag_reg && !(wr_iflag && wb[asrx_pkg::ASRX_IRQ_TC_BIT]));
      er_flag_reg <= set_er ||
        (er_flag_reg && !(wr_iflag && wb[asrx_pkg::ASRX_IRQ_ER_BIT]));
    end
  end

  // ****************************************
  // Interrupt outputs
  // ****************************************
  logic rc_irq_reg;
  logic tc_irq_reg;
  logic er_irq_reg;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rc_irq_reg <= 1'b0;
      tc_irq_reg <= 1'b0;
      er_irq_reg <= 1'b0;
    end else begin
      rc_irq_reg <= rc_flag_reg && imask_reg[asrx_pkg::ASRX_IRQ_RC_BIT] && cpu_irq_enable_in;
      tc_irq_reg <= tc_flag_reg && imask_reg[asrx_pkg::ASRX_IRQ_TC_BIT] && cpu_irq_enable_in;
      er_irq_reg <= er_flag_reg && imask_reg[asrx_pkg::ASRX_IRQ_ER_BIT] && cpu_irq_enable_in;
    end
  end

  // ****************************************
  // Bus read side
  // ****************************************
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  wire rx_busy = (rx_state_reg != ASRX_IDLE);
  wire [7:0] rd_ctrl = {1'b0, mode8_reg, pen_reg, psense_reg, rx_busy, receive_enable_bit_reg,
                        tx_busy_reg, transmit_enable_bit_reg};
  wire rd_hit = (s_axi_araddr_in == asrx_pkg::ASRX_CTRL_OFF) ||
                (s_axi_araddr_in == asrx_pkg::ASRX_STAT_OFF) ||
                (s_axi_araddr_in == asrx_pkg::ASRX_DATA_OFF) ||
                (s_axi_araddr_in == asrx_pkg::ASRX_IFLAG_OFF) ||
                (s_axi_araddr_in == asrx_pkg::ASRX_IMASK_OFF);
  wire [7:0] rd_byte =
    (s_axi_araddr_in == asrx_pkg::ASRX_CTRL_OFF) ? rd_ctrl :
    (s_axi_araddr_in == asrx_pkg::ASRX_STAT_OFF) ? {5'h00, fer_reg, per_reg, oer_reg} :
    (s_axi_araddr_in == asrx_pkg::ASRX_DATA_OFF) ? rx_buf_reg :
    (s_axi_araddr_in == asrx_pkg::ASRX_IFLAG_OFF) ?
      {5'h00, er_flag_reg, tc_flag_reg, rc_flag_reg} :
    (s_axi_araddr_in == asrx_pkg::ASRX_IMASK_OFF) ? {5'h00, imask_reg} : 8'h00;
  wire ar_take = s_axi_arvalid_in && !rvalid_reg;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= asrx_pkg::ASRX_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h000000, rd_byte};
      rresp_reg <= rd_hit ? asrx_pkg::ASRX_RESP_OKAY : asrx_pkg::ASRX_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready_in) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ****************************************
  // Output ready flops
  // ****************************************
  logic awready_reg;
  logic wready_reg;
  logic arready_reg;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      arready_reg <= 1'b0;
    end else begin
      awready_reg <= aw_take;
      wready_reg <= w_take;
      arready_reg <= ar_take;
    end
  end

  assign s_axi_awready_out = awready_reg;
  assign s_axi_wready_out = wready_reg;
  assign s_axi_arready_out = arready_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign serial_output_line_out = sout_reg;
  assign rx_complete_irq_out = rc_irq_reg;
  assign tx_complete_irq_out = tc_irq_reg;
  assign error_irq_out = er_irq_reg;

endmodule

/* testbench/asrx_props.sv */
// Checker of bus and interrupt output timing for the serial receiver
`timescale 1ns/10ps
module asrx_props #(
  parameter int DIV_W = 16
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [DIV_W-1:0] shift_clk_div_in,
  input wire logic serial_input_line_in,
  input wire logic serial_output_line_out,
  input wire logic cpu_irq_enable_in,
  input wire logic error_irq_out,
  input wire logic rx_complete_irq_out,
  input wire logic tx_complete_irq_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  rc_irq_gate_a: assert property (rx_complete_irq_out |-> $past(cpu_irq_enable_in))
    else $error("rx complete irq without global enable");
  er_irq_gate_a: assert property (error_irq_out |-> $past(cpu_irq_enable_in))
    else $error("error irq without global enable");
  tc_irq_gate_a: assert property (tx_complete_irq_out |-> $past(cpu_irq_enable_in))
    else $error("tx complete irq without global enable");
  irq_off_a: assert property (!cpu_irq_enable_in |=>
    !(error_irq_out || rx_complete_irq_out || tx_complete_irq_out))
    else $error("irq raised while globally disabled");
  bresp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
  rd_cause_a: assert property ($rose(s_axi_rvalid_out) |-> $past(s_axi_arvalid_in))
    else $error("read answer without request");
  rd_upper_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  rd_err_zero_a: assert property (s_axi_rvalid_out && s_axi_rresp_out == 2'b10 |->
    s_axi_rdata_out == 32'h0) else $error("refused read returns data");
endmodule

/* testbench/asrx_ser_src.sv */
// Serial transmitter model that drives the receiver input line
`timescale 1ns/10ps
module asrx_ser_src (
  input wire logic clk_in,
  output logic line_out
);
  initial line_out = 1'b1;
  task automatic send(input logic [7:0] v, input logic pen, input logic odd,
    input logic badp, input logic stop, input logic m8, input int bit_clks);
    logic [10:0] f;
    logic [7:0] dv;
    int n;
    dv = m8 ? v : {1'b0, v[6:0]};
    if (m8) f = pen ? {stop, ^dv ^ odd ^ badp, dv, 1'b0} : {1'b1, stop, dv, 1'b0};
    else f = pen ? {1'b1, stop, ^dv ^ odd ^ badp, dv[6:0], 1'b0} : {2'b11, stop, dv[6:0], 1'b0};
    n = (m8 ? 10 : 9) + (pen ? 1 : 0);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      line_out <= f[i];
      repeat ((i == n - 1) ? bit_clks / 2 + 1 : bit_clks - 1) @(posedge clk_in);
    end
    line_out <= 1'b1;
    repeat (bit_clks) @(posedge clk_in);
  endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench for the serial receiver block
`timescale 1ns/10ps
module tb;
  logic sys_clk, reset_n, awvalid, wvalid, bready, arvalid, rready, cpu_en, unacked;
  logic awready, wready, bvalid, arready, rvalid, ser_in, ser_out, er_irq, rc_irq, tc_irq;
  logic [7:0] awaddr, araddr, exp_d;
  logic [31:0] wdata, rdata, ctrl, d, seed;
  logic [1:0] bresp, rresp, r;
  logic [2:0] exp_st, exp_if, msk;
  logic [9:0] txb;
  int n_fail, tests_run, k, i, s;
  asrx_uart dut_u (
    .sys_clk_in(sys_clk), .reset_n_in(reset_n), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .shift_clk_div_in(16'h7), .serial_input_line_in(ser_in),
    .serial_output_line_out(ser_out), .cpu_irq_enable_in(cpu_en), .error_irq_out(er_irq),
    .rx_complete_irq_out(rc_irq), .tx_complete_irq_out(tc_irq)
  );
  asrx_ser_src src_u (.clk_in(sys_clk), .line_out(ser_in));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ****
  // Checks and bus tasks
  // ****
  task automatic end_of_test();
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    {awvalid, wvalid, bready} <= 3'h7;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && k < 50);
    if (!bvalid) n_fail++;
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && k < 50);
    if (!rvalid) n_fail++;
    r = rresp;
    rready <= 1'b0;
    chk(rdata, e);
  endtask
  task automatic ack();
    wr(8'h00, ctrl | 32'h8);
    unacked = 1'b0;
  endtask
  task automatic frame(input logic [7:0] v, input logic badp, input logic stop, input logic clr);
    logic [31:0] rv;
    logic [2:0] e;
    rv = $random(seed);
    msk = rv[2:0];
    wr(8'h10, {29'h0, msk});
    cpu_en <= rv[3];
    src_u.send(v, ctrl[5], ctrl[4], badp, stop, ctrl[6], 8);
    if (ctrl[2]) begin
      e = {~stop, ctrl[5] & badp, unacked};
      exp_st = exp_st | e;
      exp_if = exp_if | {(e != 3'h0), 1'b0, ~unacked};
      exp_d = ctrl[6] ? v : {1'b0, v[6:0]};
      unacked = 1'b1;
    end
    repeat (16) @(posedge sys_clk);
    rd_chk(8'h08, {24'h0, exp_d});
    rd_chk(8'h04, {29'h0, exp_st});
    rd_chk(8'h0c, {29'h0, exp_if});
    chk({29'h0, er_irq, tc_irq, rc_irq}, {29'h0, exp_if & msk & {3{cpu_en}}});
    wr(8'h0c, 32'h7);
    exp_if = 3'h0;
    rd_chk(8'h0c, 32'h0);
    if (clr && exp_st != 3'h0) begin
      wr(8'h04, 32'h0);
      rd_chk(8'h04, {29'h0, exp_st});
      wr(8'h04, {29'h0, exp_st});
      exp_st = 3'h0;
      rd_chk(8'h04, 32'h0);
    end
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    seed = 32'he59c01e6;
    reset_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {cpu_en, unacked, exp_d, exp_st, exp_if, msk, ctrl} = '0;
    n_fail = 0;
    tests_run = 0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd_chk(8'h00, 32'h40);
    rd_chk(8'h14, 32'h0);
    chk({30'h0, r}, {30'h0, asrx_pkg::ASRX_RESP_SLVERR});
    wr(8'h14, 32'h1);
    chk({30'h0, r}, {30'h0, asrx_pkg::ASRX_RESP_SLVERR});
    ctrl = 32'h44;
    wr(8'h00, ctrl);
    for (i = 0; i < 5; i++) begin
      d = $random(seed);
      frame(d[7:0], 1'b0, 1'b1, 1'b1);
      if (i != 3) ack();
    end
    for (s = 0; s < 4; s++) begin
      ctrl = {25'h0, s[1], 1'b1, s[0], 4'h4};
      wr(8'h00, ctrl);
      for (i = 0; i < 2; i++) begin
        d = $random(seed);
        frame(d[7:0], i[0], 1'b1, 1'b1);
        ack();
      end
    end
    ctrl = 32'h44;
    wr(8'h00, ctrl);
    frame(8'h81, 1'b0, 1'b0, 1'b0);
    ack();
    ctrl = 32'h40;
    wr(8'h00, ctrl);
    exp_st = 3'h0;
    frame(8'h5a, 1'b0, 1'b1, 1'b1);
    ctrl = 32'h45;
    wr(8'h00, ctrl);
    d = $random(seed);
    wr(8'h08, {24'h0, d[7:0]});
    wr(8'h00, ctrl | 32'h2);
    k = 0;
    while (ser_out === 1'b1 && k < 400) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 400) n_fail++;
    repeat (4) @(posedge sys_clk);
    for (i = 0; i < 10; i++) begin
      txb[i] = ser_out;
      repeat (8) @(posedge sys_clk);
    end
    chk({22'h0, txb}, {22'h0, 1'b1, d[7:0], 1'b0});
    rd_chk(8'h0c, 32'h2);
    chk({31'h0, tc_irq}, {31'h0, msk[1] & cpu_en});
    wr(8'h00, 32'h44);
    rd_chk(8'h00, 32'h44);
    end_of_test();
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_fail++;
    end_of_test();
  end
endmodule
bind asrx_uart asrx_props #(.DIV_W(DIV_W)) props_u (.*);
